// ==== src/pea_pkg.sv ====
// Package of register offsets, field layouts and types for the energy block.
package pea_pkg;

  // Width of the serial register address field.
  localparam int ADDR_W = 12;

  // Voltage scale factor register offset and reset value.
  localparam logic [11:0] VSCALE_OFS   = 12'h014;
  localparam logic [15:0] VSCALE_RESET = 16'h0001;

  // Per-phase current magnitude offsets, phase A first.
  localparam logic [11:0] CUR_OFS [0:2] = '{12'h1CC, 12'h2B8, 12'h3A4};

  // Per-phase wrap flag register offsets.
  localparam logic [11:0] FLAG_OFS [0:2] = '{12'h146, 12'h232, 12'h31E};

  // Energy offsets per phase: real fwd, real rev, quad fwd, quad rev, VA.
  localparam logic [11:0] ENERGY_OFS [0:2][0:4] = '{
    '{12'h1E8, 12'h1EC, 12'h1F0, 12'h1F4, 12'h1F8},
    '{12'h2D4, 12'h2D8, 12'h2DC, 12'h2E0, 12'h2E4},
    '{12'h3C0, 12'h3C4, 12'h3C8, 12'h3CC, 12'h3D0}
  };

  // Wrap flag bit positions inside a flag register.
  localparam int REAL_FWD_WRAP_BIT = 0;
  localparam int REAL_REV_WRAP_BIT = 1;
  localparam int QUAD_FWD_WRAP_BIT = 2;
  localparam int QUAD_REV_WRAP_BIT = 3;
  localparam int VA_WRAP_BIT       = 4;
  localparam int NUM_ACCUM         = 5;
  localparam logic [2:0] FLAG_RSV  = 3'h0;

  // Accumulator reset value.
  localparam logic [31:0] ACCUM_RESET = 32'h0000_0000;

  // Serial frame layout: command bits, then data bits.
  localparam logic [5:0] CMD_BITS   = 6'h10;
  localparam logic [5:0] FRAME_BITS = 6'h30;
  localparam int         CMD_WR_BIT = 15;

  // How an accumulator treats the sign of its sample.
  typedef enum logic [1:0] {
    ACC_FWD = 2'h0,
    ACC_REV = 2'h1,
    ACC_ALL = 2'h2
  } pea_acc_mode_type;

  // Accumulator kinds, indexed by flag bit position.
  localparam pea_acc_mode_type ACC_MODE [0:4] =
    '{ACC_FWD, ACC_REV, ACC_FWD, ACC_REV, ACC_ALL};

  // Serial port states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b100
  } pea_spi_state_type;

endpackage

// ==== src/pea_accum.sv ====
// One energy accumulator with its sticky wrap flag.
module pea_accum
  import pea_pkg::*;
#(
  parameter pea_acc_mode_type MODE = ACC_ALL
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        strobe_i,
  input  wire logic [31:0] sample_i,
  input  wire logic        clear_i,
  output logic      [31:0] accum_o,
  output logic             wrap_o
);

  typedef struct packed {
    logic [31:0] accum;
    logic        wrap;
  } pea_acc_state_type;

  pea_acc_state_type st_reg;
  pea_acc_state_type st_next;
  logic [31:0]       addend;
  logic [32:0]       sum;

  // Pick the addend by sign, add, and raise the wrap flag on carry out.
  always_comb begin
    addend = 32'h0000_0000;
    case (MODE)
      ACC_FWD: if (!sample_i[31]) addend = sample_i;
      ACC_REV: if (sample_i[31]) addend = 32'h0 - sample_i;
      default: addend = sample_i;
    endcase
    sum = {1'b0, st_reg.accum} + {1'b0, addend};
    st_next = st_reg;
    if (strobe_i) begin
      st_next.accum = sum[31:0];
    end
    // Set beats clear so a wrap in the clearing cycle is never lost.
    if (clear_i) begin
      st_next.wrap = 1'b0;
    end
    if (strobe_i && sum[32]) begin
      st_next.wrap = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '{accum: ACCUM_RESET, wrap: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign accum_o = st_reg.accum;
  assign wrap_o  = st_reg.wrap;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  wrap_on_carry_a: assert property (strobe_i && sum[32] |=> wrap_o)
    else $error("wrap flag not set on accumulator carry");
  wrap_sticky_a: assert property (wrap_o && !clear_i |=> wrap_o)
    else $error("wrap flag dropped without a clear");
  accum_step_a: assert property (strobe_i |=>
      accum_o == $past(accum_o) + $past(addend))
    else $error("accumulator did not add its sample");
  accum_hold_a: assert property (!strobe_i |=> $stable(accum_o))
    else $error("accumulator changed without a cycle strobe");
  rev_sign_a: assert property (MODE == ACC_REV && strobe_i &&
      !sample_i[31] |=> $stable(accum_o))
    else $error("reverse accumulator took a positive sample");

endmodule

// ==== src/pea_top.sv ====
// Per-phase energy accumulators, RMS results and serial register port.
module pea_top
  import pea_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             dsp_cycle_i,
  input  wire logic [2:0][31:0] phase_current_magnitude_i,
  input  wire logic [2:0][31:0] phase_voltage_magnitude_i,
  input  wire logic [2:0][31:0] real_power_sample_i,
  input  wire logic [2:0][31:0] quadrature_power_sample_i,
  input  wire logic [2:0][31:0] va_power_sample_i,
  input  wire logic             spi_sclk_i,
  input  wire logic             spi_cs_n_i,
  input  wire logic             spi_mosi_i,
  output logic                  spi_miso_o,
  output logic                  spi_miso_oe_n_o,
  output logic      [2:0][47:0] phase_voltage_user_o
);

  typedef struct packed {
    logic [2:0]        sclk_sync;
    logic [2:0]        cs_sync;
    logic [2:0]        mosi_sync;
    logic              sclk_lvl;
    logic              cs_lvl;
    logic              mosi_lvl;
    pea_spi_state_type state;
    logic [5:0]        bit_cnt;
    logic [15:0]       cmd;
    logic [31:0]       rx_sr;
    logic [31:0]       tx_sr;
    logic              miso;
    logic [15:0]       scale;
    logic [2:0][31:0]  cur;
    logic [2:0][47:0]  volt;
    logic [2:0][4:0]   clear;
  } pea_top_state_type;

  pea_top_state_type st_reg;
  pea_top_state_type st_next;

  logic [2:0][4:0][31:0] acc;
  logic [2:0][4:0]       wrap;
  logic [2:0][4:0][31:0] smp;
  logic                  sclk_upd;
  logic                  cs_upd;
  logic                  mosi_upd;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic [15:0]           cmd_shift;
  logic [31:0]           rx_shift;
  logic [31:0]           rd_word;
  logic [11:0]           wr_addr;

  // Route each phase's samples to its five accumulators.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      smp[p][REAL_FWD_WRAP_BIT] = real_power_sample_i[p];
      smp[p][REAL_REV_WRAP_BIT] = real_power_sample_i[p];
      smp[p][QUAD_FWD_WRAP_BIT] = quadrature_power_sample_i[p];
      smp[p][QUAD_REV_WRAP_BIT] = quadrature_power_sample_i[p];
      smp[p][VA_WRAP_BIT]       = va_power_sample_i[p];
    end
  end

  // Fifteen accumulators; the kind sets how the sample sign is treated.
  for (genvar p = 0; p < 3; p++) begin : g_phase
    for (genvar k = 0; k < NUM_ACCUM; k++) begin : g_kind
      pea_accum #(
        .MODE (ACC_MODE[k])
      ) u_accum (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .strobe_i  (dsp_cycle_i),
        .sample_i  (smp[p][k]),
        .clear_i   (st_reg.clear[p][k]),
        .accum_o   (acc[p][k]),
        .wrap_o    (wrap[p][k])
      );
    end
  end

  // Pin levels count only once the second and third sync stages agree.
  always_comb begin
    sclk_upd = st_reg.sclk_lvl;
    cs_upd   = st_reg.cs_lvl;
    mosi_upd = st_reg.mosi_lvl;
    if (st_reg.sclk_sync[1] == st_reg.sclk_sync[2]) begin
      sclk_upd = st_reg.sclk_sync[2];
    end
    if (st_reg.cs_sync[1] == st_reg.cs_sync[2]) begin
      cs_upd = st_reg.cs_sync[2];
    end
    if (st_reg.mosi_sync[1] == st_reg.mosi_sync[2]) begin
      mosi_upd = st_reg.mosi_sync[2];
    end
    sclk_rise = sclk_upd && !st_reg.sclk_lvl;
    sclk_fall = !sclk_upd && st_reg.sclk_lvl;
  end

  // Incoming shift values and the write target address.
  assign cmd_shift = {st_reg.cmd[14:0], mosi_upd};
  assign rx_shift  = {st_reg.rx_sr[30:0], mosi_upd};
  assign wr_addr   = st_reg.cmd[ADDR_W-1:0];

  // Read map; unmapped addresses read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (cmd_shift[ADDR_W-1:0] == VSCALE_OFS) begin
      rd_word = {16'h0000, st_reg.scale};
    end
    for (int p = 0; p < 3; p++) begin
      if (cmd_shift[ADDR_W-1:0] == CUR_OFS[p]) begin
        rd_word = st_reg.cur[p];
      end
      if (cmd_shift[ADDR_W-1:0] == FLAG_OFS[p]) begin
        rd_word = {24'h000000, FLAG_RSV, wrap[p]};
      end
      for (int k = 0; k < NUM_ACCUM; k++) begin
        if (cmd_shift[ADDR_W-1:0] == ENERGY_OFS[p][k]) begin
          rd_word = acc[p][k];
        end
      end
    end
  end

  // Next state: synchronisers, serial frame engine and result latches.
  always_comb begin
    st_next = st_reg;
    st_next.sclk_sync = {st_reg.sclk_sync[1:0], spi_sclk_i};
    st_next.cs_sync   = {st_reg.cs_sync[1:0], spi_cs_n_i};
    st_next.mosi_sync = {st_reg.mosi_sync[1:0], spi_mosi_i};
    st_next.sclk_lvl  = sclk_upd;
    st_next.cs_lvl    = cs_upd;
    st_next.mosi_lvl  = mosi_upd;
    st_next.clear     = '0;
    case (st_reg.state)
      ST_IDLE: begin
        st_next.bit_cnt = 6'h00;
        st_next.tx_sr   = 32'h0000_0000;
        if (!cs_upd) begin
          st_next.state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (sclk_rise) begin
          st_next.cmd     = cmd_shift;
          st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
          // Load read data right after the last command bit.
          if (st_reg.bit_cnt == CMD_BITS - 6'h01) begin
            st_next.tx_sr = rd_word;
            st_next.state = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (sclk_rise && st_reg.bit_cnt != FRAME_BITS) begin
          st_next.rx_sr   = rx_shift;
          st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
          // A write takes effect on the last data bit only.
          if (st_reg.bit_cnt == FRAME_BITS - 6'h01 &&
              st_reg.cmd[CMD_WR_BIT]) begin
            if (wr_addr == VSCALE_OFS) begin
              st_next.scale = rx_shift[15:0];
            end
            for (int p = 0; p < 3; p++) begin
              if (wr_addr == FLAG_OFS[p]) begin
                st_next.clear[p] = rx_shift[4:0];
              end
            end
          end
        end
        // Shift out only after the host sampled the current bit.
        if (sclk_fall && st_reg.bit_cnt > CMD_BITS &&
            st_reg.bit_cnt < FRAME_BITS) begin
          st_next.tx_sr = {st_reg.tx_sr[30:0], 1'b0};
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
    // Deselect aborts any frame; a partial write changes nothing.
    if (cs_upd) begin
      st_next.state   = ST_IDLE;
      st_next.bit_cnt = 6'h00;
    end
    st_next.miso = (st_reg.state == ST_DATA) ? st_next.tx_sr[31] : 1'b0;
    // Results refresh once per processing cycle.
    if (dsp_cycle_i) begin
      for (int p = 0; p < 3; p++) begin
        st_next.cur[p]  = phase_current_magnitude_i[p];
        st_next.volt[p] = {16'h0000, phase_voltage_magnitude_i[p]} *
                          {32'h0000_0000, st_reg.scale};
      end
    end
  end

  // State register; pins idle high for select, low for clock and data.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg           <= '0;
      st_reg.cs_sync   <= 3'h7;
      st_reg.cs_lvl    <= 1'b1;
      st_reg.state     <= ST_IDLE;
      st_reg.scale     <= VSCALE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // The data pin is released whenever the device is not selected.
  assign spi_miso_o           = st_reg.miso;
  assign spi_miso_oe_n_o      = st_reg.cs_lvl;
  assign phase_voltage_user_o = st_reg.volt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence last_bit_s;
    st_reg.state == ST_DATA && sclk_rise &&
      st_reg.bit_cnt == FRAME_BITS - 6'h01 && !cs_upd;
  endsequence

  sequence flag_write_s;
    last_bit_s ##0 (st_reg.cmd[CMD_WR_BIT] &&
      wr_addr == FLAG_OFS[0] && rx_shift[0]);
  endsequence

  // Read data enters the shifter right after the last command bit.
  sequence cmd_done_s;
    st_reg.state == ST_CMD && sclk_rise &&
      st_reg.bit_cnt == CMD_BITS - 6'h01 && !cs_upd;
  endsequence

  // The first data bit stands on the pin until the falling edge after its sampling rise.
  sequence first_data_s;
    cmd_done_s ##1 (st_reg.state == ST_DATA && !sclk_fall);
  endsequence

  // A falling edge inside the data phase moves the next bit out.
  sequence data_fall_s;
    st_reg.state == ST_DATA && sclk_fall &&
      st_reg.bit_cnt > CMD_BITS && st_reg.bit_cnt < FRAME_BITS;
  endsequence

  // Phase C flag write with the volt-ampere bit set.
  sequence flag_write_c_s;
    last_bit_s ##0 (st_reg.cmd[CMD_WR_BIT] &&
      wr_addr == FLAG_OFS[2] && rx_shift[VA_WRAP_BIT]);
  endsequence

  volt_scale_a: assert property (dsp_cycle_i |=>
      phase_voltage_user_o[0] == $past(phase_voltage_magnitude_i[0]) *
      $past(st_reg.scale))
    else $error("user voltage is not raw voltage times scale");
  cur_latch_a: assert property (dsp_cycle_i |=>
      st_reg.cur[1] == $past(phase_current_magnitude_i[1]))
    else $error("current magnitude not latched on cycle");
  flag_clear_a: assert property (flag_write_s |=>
      st_reg.clear[0][0] ##1 !st_reg.clear[0][0])
    else $error("flag clear pulse missing or too long");
  scale_write_a: assert property (last_bit_s ##0 (st_reg.cmd[CMD_WR_BIT]
      && wr_addr == VSCALE_OFS) |=> st_reg.scale == $past(rx_shift[15:0]))
    else $error("scale factor write not applied");
  miso_release_a: assert property ($rose(spi_miso_oe_n_o) |=> !spi_miso_o)
    else $error("data pin not parked low after deselect");

  // Serial read path: a late load or a lost shift corrupts every read.
  tx_load_a: assert property (cmd_done_s |=>
      st_reg.tx_sr == $past(rd_word) && st_reg.state == ST_DATA)
    else $error("read word not loaded after the command");
  first_bit_a: assert property (first_data_s |=>
      spi_miso_o == $past(st_reg.tx_sr[31]))
    else $error("first data bit not on the pin");
  shift_out_a: assert property (data_fall_s |=>
      st_reg.tx_sr == {$past(st_reg.tx_sr[30:0]), 1'b0} &&
      spi_miso_o == $past(st_reg.tx_sr[30]))
    else $error("data bit not shifted out on a falling edge");

  // Flag clears and scale change only through a completed host write.
  flag_clear_c_a: assert property (flag_write_c_s |=>
      st_reg.clear[2][VA_WRAP_BIT] ##1 !st_reg.clear[2][VA_WRAP_BIT])
    else $error("phase C flag clear pulse missing or too long");
  clear_idle_a: assert property (
      !(st_reg.state == ST_DATA && sclk_rise) |=> st_reg.clear == '0)
    else $error("flag clear without a host write");
  scale_hold_a: assert property (
      !(st_reg.state == ST_DATA && sclk_rise) |=> $stable(st_reg.scale))
    else $error("scale factor changed without a host write");
  flag_rsv_a: assert property (
      cmd_shift[ADDR_W-1:0] == FLAG_OFS[1] |-> rd_word[7:5] == FLAG_RSV)
    else $error("reserved flag bits read as nonzero");

  // Result latches follow each processing cycle and hold otherwise.
  cur_phases_a: assert property (dsp_cycle_i |=>
      st_reg.cur[0] == $past(phase_current_magnitude_i[0]) &&
      st_reg.cur[2] == $past(phase_current_magnitude_i[2]))
    else $error("phase A or C current not latched on cycle");
  volt_phase_b_a: assert property (dsp_cycle_i |=>
      phase_voltage_user_o[1] == $past(phase_voltage_magnitude_i[1]) *
      $past(st_reg.scale))
    else $error("phase B user voltage is not raw voltage times scale");
  volt_phase_c_a: assert property (dsp_cycle_i |=>
      phase_voltage_user_o[2] == $past(phase_voltage_magnitude_i[2]) *
      $past(st_reg.scale))
    else $error("phase C user voltage is not raw voltage times scale");
  result_hold_a: assert property (!dsp_cycle_i |=>
      $stable(st_reg.cur) && $stable(st_reg.volt))
    else $error("results changed without a processing cycle");

  // Frame engine bookkeeping; a stray count would shift the data window.
  state_onehot_a: assert property ($onehot(st_reg.state))
    else $error("serial port state is not one-hot");
  bit_count_a: assert property (st_reg.bit_cnt <= FRAME_BITS)
    else $error("frame bit count ran past the frame");
  frame_abort_a: assert property (cs_upd |=>
      st_reg.state == ST_IDLE && st_reg.bit_cnt == 6'h00)
    else $error("deselect did not abort the frame");
  frame_open_a: assert property (st_reg.state == ST_IDLE && !cs_upd |=>
      st_reg.state == ST_CMD && st_reg.bit_cnt == 6'h00)
    else $error("frame did not open on select");
  // The pin filter only reports a change that two stages agree on.
  sclk_filter_a: assert property (sclk_rise |->
      st_reg.sclk_sync[1] && st_reg.sclk_sync[2])
    else $error("serial clock edge taken before the filter agreed");

endmodule

// ==== verif/pea_spi_host.sv ====
// Serial host model: a mode 0 master that runs 48-bit register frames.
module pea_spi_host (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Wide half period, so the three-flop pin filter never misses an edge.
  localparam int HALF = 8;

  // Idle levels: serial clock low, select high.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One frame of 16 command and 32 data bits, MSB first; data out is
  // sampled on the rises that follow the command.
  task automatic xfer(input  logic [15:0] cmd,
                      input  logic [31:0] wdata,
                      output logic [31:0] rdata);
    logic [47:0] frame;
    frame = {cmd, wdata};
    rdata = 32'h0000_0000;
    @(posedge clk_i) cs_n_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    for (int i = 47; i >= 0; i--) begin
      mosi_o <= frame[i];
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b1;
      if (i < 32) rdata[i] = miso_i;
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // A released data line flips, so a stale bit never looks driven.
    mosi_o <= ~mosi_o;
    // Gap lets a write land and keeps select high between frames.
    repeat (2 * HALF) @(posedge clk_i);
  endtask
endmodule

// ==== verif/test_pea_top.sv ====
// Self-checking bench for the phase energy block and its serial port.
module test_pea_top
  import pea_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic             clk_i       = 1'b0;
  logic             reset_n_i   = 1'b0;
  logic             dsp_cycle_i = 1'b0;
  logic [2:0][31:0] cur_mag     = '0;
  logic [2:0][31:0] volt_mag    = '0;
  logic [2:0][31:0] real_s      = '0;
  logic [2:0][31:0] quad_s      = '0;
  logic [2:0][31:0] va_s        = '0;
  logic             sclk;
  logic             cs_n;
  logic             mosi;
  logic             miso;
  logic             miso_oe_n;
  logic             miso_last   = 1'b0;
  logic             miso_w;
  logic [2:0][47:0] volt_user;
  logic [31:0]      ea [0:2][0:4] = '{default: ACCUM_RESET};
  logic [4:0]       ef [0:2]      = '{default: 5'h00};
  int               err_total   = 0;
  int               tests_run   = 0;

  // Free-running 25 MHz clock.
  always #20 clk_i = ~clk_i;

  // Released data line shows the inverse of its last driven level.
  always @(posedge clk_i) if (!miso_oe_n) miso_last <= miso;
  assign miso_w = miso_oe_n ? ~miso_last : miso;

  pea_top i_pea_top (
    .clk_i                     (clk_i),
    .reset_n_i                 (reset_n_i),
    .dsp_cycle_i               (dsp_cycle_i),
    .phase_current_magnitude_i (cur_mag),
    .phase_voltage_magnitude_i (volt_mag),
    .real_power_sample_i       (real_s),
    .quadrature_power_sample_i (quad_s),
    .va_power_sample_i         (va_s),
    .spi_sclk_i                (sclk),
    .spi_cs_n_i                (cs_n),
    .spi_mosi_i                (mosi),
    .spi_miso_o                (miso),
    .spi_miso_oe_n_o           (miso_oe_n),
    .phase_voltage_user_o      (volt_user)
  );

  pea_spi_host i_pea_spi_host (
    .clk_i  (clk_i),
    .miso_i (miso_w),
    .sclk_o (sclk),
    .cs_n_o (cs_n),
    .mosi_o (mosi)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Reads one register and compares it.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_pea_spi_host.xfer({4'h0, a}, 32'h0000_0000, d);
    check({16'h0000, d}, {16'h0000, exp});
  endtask

  // Writes one register; read data of a write frame is ignored.
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    i_pea_spi_host.xfer({4'h8, a}, d, dummy);
  endtask

  // Strobes n back-to-back processing cycles and advances the expected
  // accumulators from the samples held on the inputs.
  task automatic pulse(input int n);
    logic [31:0] s;
    logic [32:0] sum;
    repeat (n) begin
      @(posedge clk_i) dsp_cycle_i <= 1'b1;
      for (int p = 0; p < 3; p++) begin
        for (int k = 0; k < NUM_ACCUM; k++) begin
          s = (k < 2) ? real_s[p] : (k < 4) ? quad_s[p] : va_s[p];
          if (ACC_MODE[k] == ACC_REV) s = s[31] ? -s : 32'h0000_0000;
          else if (ACC_MODE[k] == ACC_FWD && s[31]) s = 32'h0000_0000;
          sum = {1'b0, ea[p][k]} + {1'b0, s};
          ea[p][k] = sum[31:0];
          if (sum[32]) ef[p][k] = 1'b1;
        end
      end
    end
    @(posedge clk_i) dsp_cycle_i <= 1'b0;
  endtask

  // Reads every accumulator and flag register of all three phases.
  task automatic check_all();
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < NUM_ACCUM; k++)
        rd_chk(ENERGY_OFS[p][k], ea[p][k]);
      rd_chk(FLAG_OFS[p], {27'h0, ef[p]});
    end
  endtask

  // Voltage results against raw voltage times the given scale.
  task automatic check_volt(input logic [15:0] sc);
    @(negedge clk_i);
    for (int p = 0; p < 3; p++)
      check(volt_user[p], {16'h0000, volt_mag[p]} * {32'h0, sc});
  endtask

  // Bounds the whole run; running out counts as a mismatch.
  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end

  // Main sequence: reset, mixed signs, wraps, flag clears, scale.
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd_chk(VSCALE_OFS, {16'h0000, VSCALE_RESET});
    check_all();
    rd_chk(12'h000, 32'h0000_0000);
    cur_mag  <= {32'h00FF_FFFF, 32'h0100_0000, 32'h8000_0001};
    real_s   <= {32'h0000_0000, 32'hFFFF_FFF9, 32'h0000_0005};
    quad_s   <= {32'h0000_0003, 32'h0000_0002, 32'hFFFF_FFFE};
    va_s     <= {32'h0000_0010, 32'h0000_0020, 32'h0000_0030};
    volt_mag <= {32'h0000_0004, 32'h00FF_FFFF, 32'hFFFF_FFFF};
    pulse(2);
    check_volt(VSCALE_RESET);
    check_all();
    for (int p = 0; p < 3; p++)
      rd_chk(CUR_OFS[p], cur_mag[p]);
    // Boundary samples that carry out of every kind of accumulator.
    real_s <= {32'h0000_0001, 32'h8000_0000, 32'h7FFF_FFFF};
    quad_s <= {32'h8000_0001, 32'h7FFF_FFFF, 32'h8000_0000};
    va_s   <= {3{32'hFFFF_FFFF}};
    pulse(3);
    check_all();
    rd_chk(ENERGY_OFS[2][4], ea[2][4]);
    // Flags must survive idle cycles and clear only where written.
    real_s <= '0;
    quad_s <= '0;
    va_s   <= '0;
    pulse(1);
    wr_reg(FLAG_OFS[0], 32'h0000_0001);
    ef[0][0] = 1'b0;
    wr_reg(FLAG_OFS[2], 32'hFFFF_FFFF);
    ef[2] = 5'h00;
    for (int p = 0; p < 3; p++)
      rd_chk(FLAG_OFS[p], {27'h0, ef[p]});
    wr_reg(ENERGY_OFS[1][4], 32'h1234_5678);
    rd_chk(ENERGY_OFS[1][4], ea[1][4]);
    // Scale above 1000 keeps conversion loss low.
    wr_reg(VSCALE_OFS, 32'hABCD_03E9);
    rd_chk(VSCALE_OFS, 32'h0000_03E9);
    pulse(1);
    repeat (2) @(posedge clk_i);
    check_volt(16'h03E9);
    print_verdict();
  end
endmodule
